/* File: rtl/adcsq_top.sv */
// Purpose: Control and sequencing of the 10-bit converter
// Assumes: clock is the bus E clock; rc_osc and cmp_in are asynchronous
// Notes: Registers on a plain strobe port, read data one cycle later
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module adcsq_top (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    // Analog side
    input wire logic rc_osc,
    input wire logic cmp_in,
    output logic [3:0] analog_src,
    output logic sample_hold,
    output logic [9:0] dac_code,
    output logic adc_enable,
    output logic seq_busy
);
    typedef struct packed {
        adcsq_pkg::adcsq_ctl_s ctl;
        logic half;
        logic pwr;
        logic clock_source_select;
        adcsq_pkg::adcsq_seq_e st;
        logic [2:0] slot;
        logic [7:0][9:0] res;
        logic [7:0] rd;
        logic div;
        logic [2:0] rcs;
        logic [1:0] cmps;
        logic tick;
        logic sar_start;
        logic sar_abort;
        logic busy;
    } adcsq_top_s;

    adcsq_top_s q, n;
    adcsq_pkg::adcsq_bus_s bus;
    logic sar_done;
    logic [9:0] sar_code;
    logic rc_edge;

    assign bus.addr = addr;
    assign bus.wdata = wr_data;
    assign bus.wr = wr_stb;
    assign bus.rd = rd_stb;
    assign rc_edge = q.rcs[1] & ~q.rcs[2];

    adcsq_mux u_mux (
        .clock(clock),
        .nrst(nrst),
        .ch(q.ctl.ch),
        .src_r(analog_src)
    );

    adcsq_sar u_sar (
        .clock(clock),
        .nrst(nrst),
        .tick(q.tick),
        .start(q.sar_start),
        .abort(q.sar_abort),
        .cmp(q.cmps[1]),
        .sample_r(sample_hold),
        .dac_r(sar_code),
        .done_r(sar_done)
    );

    always_comb
    begin
        n = q;
        n.sar_start = 1'b0;
        n.sar_abort = 1'b0;
        n.rd = '0;

        // Input synchronisers
        n.rcs = {q.rcs[1], q.rcs[0], rc_osc};
        n.cmps = {q.cmps[0], cmp_in};

        // Conversion clock
        n.div = ~q.div;
        if (q.clock_source_select)
            n.tick = rc_edge; // [RULE_10] [RULE_05]
        else if (q.half)
            n.tick = q.div; // [RULE_21] [RULE_04]
        else
            n.tick = 1'b1; // [RULE_21] [RULE_03]

        // Result store and slot walk
        if (q.st == adcsq_pkg::ADCSQ_RUN && sar_done)
        begin
            n.res[q.slot] = sar_code; // [RULE_02] [RULE_05]
            if (q.slot == `ADCSQ_SLOT_LAST)
            begin
                n.ctl.done = 1'b1; // [RULE_20]
                if (q.ctl.repeat_scan)
                begin
                    n.slot = q.ctl.eight ? `ADCSQ_SLOT_FIRST8
                                         : `ADCSQ_SLOT_FIRST4; // [RULE_16] [RULE_18]
                    n.sar_start = 1'b1;
                end
                else
                begin
                    n.st = adcsq_pkg::ADCSQ_IDLE; // [RULE_15] [RULE_17]
                end
            end
            else
            begin
                n.slot = q.slot + 3'h1; // [RULE_14]
                n.sar_start = 1'b1;
            end
        end

        // Register writes
        if (bus.wr)
        begin
            case (bus.addr)
                `ADCSQ_ADDR_CTL:
                begin
                    n.ctl = bus.wdata;
                    n.ctl.done = 1'b0; // [RULE_19]
                    if (q.pwr)
                    begin
                        n.st = adcsq_pkg::ADCSQ_RUN; // [RULE_19]
                        n.slot = bus.wdata[6] ? `ADCSQ_SLOT_FIRST8
                                              : `ADCSQ_SLOT_FIRST4; // [RULE_14]
                        n.sar_start = 1'b1;
                    end
                    else
                    begin
                        n.st = adcsq_pkg::ADCSQ_IDLE; // [RULE_22]
                        n.sar_abort = 1'b1;
                    end
                end
                `ADCSQ_ADDR_RATE:
                begin
                    n.half = bus.wdata[`ADCSQ_RATE_HALF_BIT]; // [RULE_21]
                end
                `ADCSQ_ADDR_OPT:
                begin
                    n.pwr = bus.wdata[`ADCSQ_OPT_PWR_BIT];
                    n.clock_source_select = bus.wdata[`ADCSQ_OPT_CLOCK_SOURCE_SELECT_BIT]; // [RULE_10]
                    if (!bus.wdata[`ADCSQ_OPT_PWR_BIT])
                    begin
                        n.st = adcsq_pkg::ADCSQ_IDLE; // [RULE_08]
                        n.sar_abort = 1'b1;
                        n.sar_start = 1'b0;
                    end
                end
                default:
                begin
                    n.rd = '0;
                end
            endcase
        end

        // Register reads
        if (bus.rd)
        begin
            if (bus.addr == `ADCSQ_ADDR_CTL)
                n.rd = q.ctl;
            else if (bus.addr == `ADCSQ_ADDR_RATE)
                n.rd = {7'h00, q.half};
            else if (bus.addr == `ADCSQ_ADDR_OPT)
                n.rd = {q.pwr, q.clock_source_select, 6'h00};
            else if (bus.addr >= `ADCSQ_ADDR_RES_LO && bus.addr <= `ADCSQ_ADDR_RES_HI)
            begin
                if (bus.addr[0])
                    n.rd = {q.res[bus.addr[3:1]][1:0], 6'h00}; // [RULE_11]
                else
                    n.rd = q.res[bus.addr[3:1]][9:2]; // [RULE_11]
            end
            else
                n.rd = '0;
        end

        n.busy = (n.st == adcsq_pkg::ADCSQ_RUN);
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            q <= '0;
        else
            q <= n;
    end

    assign rd_data = q.rd;
    assign dac_code = sar_code;
    assign adc_enable = q.pwr; // [RULE_08]
    assign seq_busy = q.busy;
endmodule

/* File: rtl/adcsq_consts.svh */
// Purpose: Constants of the conversion sequencer
// Assumes: Clock is the bus E clock
// Notes: Register offsets, field positions and timing counts
// Overview of operation
// [RULE_01] Sixteen-way input mux; reserved channel codes sample the low reference.
// [RULE_02] Eight 10-bit result registers filled in mode order.
// [RULE_03] On the E clock, four conversions take exactly 144 E cycles; the code takes 38 per conversion, 152 per four.
// [RULE_04] With half rate selected, conversions run at E/2: 288 cycles per four; the code adds start and done cycles to each conversion.
// [RULE_05] On the RC clock, results land synchronously to E, one per cycle at most.
// [RULE_06] Software picks the RC clock when E is below 750 kHz.
// [RULE_07] On the RC clock, software polls the done flag.
// [RULE_08] Clearing power-up disables the converter and aborts any sequence.
// [RULE_09] Software waits about 100 us after power-up before trusting results.
// [RULE_10] Clock source select picks RC oscillator or E clock.
// [RULE_11] Results read left-justified in 16 bits; six low bits read zero.
// [RULE_12] Input sampled at conversion start, then resolved bit by bit.
// [RULE_13] Codes 0-6 port pins, 7-11 reserved, 12-14 references, 15 test.
// [RULE_14] Single channel converted four or eight times; repeat picks scan mode.
// [RULE_15] Four-conversion single scan fills results five to eight, then halts.
// [RULE_16] Four-conversion continuous scan wraps back to result five.
// [RULE_17] Eight-conversion single scan fills results one to eight, then halts.
// [RULE_18] Eight-conversion continuous scan wraps back to result one.
// [RULE_19] A control write clears the done flag, aborts and starts a sequence.
// [RULE_20] Done flag sets when all results first updated; stays until control write.
// [RULE_21] Half rate one selects E/2, zero selects E.
// [RULE_22] While powered down, control writes start nothing.
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH
`define ADCSQ_ADDR_CTL 8'h30
`define ADCSQ_ADDR_RATE 8'h32
`define ADCSQ_ADDR_OPT 8'h39
`define ADCSQ_ADDR_RES_LO 8'h40
`define ADCSQ_ADDR_RES_HI 8'h4F
`define ADCSQ_OPT_PWR_BIT 7
`define ADCSQ_OPT_CLOCK_SOURCE_SELECT_BIT 6
`define ADCSQ_RATE_HALF_BIT 0
`define ADCSQ_CTL_DONE_BIT 7
`define ADCSQ_SLOT_FIRST8 3'h0
`define ADCSQ_SLOT_FIRST4 3'h4
`define ADCSQ_SLOT_LAST 3'h7
`define ADCSQ_CH_RSV_LO 4'h7
`define ADCSQ_CH_RSV_HI 4'hB
`define ADCSQ_CH_REF_LOW 4'hD
`define ADCSQ_GROUP_TICKS 144
`define ADCSQ_CONV_TICKS (`ADCSQ_GROUP_TICKS / 4)
`define ADCSQ_SAMPLE_END 6'h05
`define ADCSQ_STEP_TICKS 2'h2
`define ADCSQ_DAC_MSB 10'h200
`endif

/* File: rtl/adcsq_pkg.sv */
// Purpose: Types of the conversion sequencer
// Assumes: Constants come from adcsq_consts.svh
// Notes: Control register layout and sequencer states
package adcsq_pkg;
    typedef struct packed {
        logic done;
        logic eight;
        logic repeat_scan;
        logic group;
        logic [3:0] ch;
    } adcsq_ctl_s;
    typedef enum logic {ADCSQ_IDLE, ADCSQ_RUN} adcsq_seq_e;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adcsq_bus_s;
endpackage

/* File: rtl/adcsq_mux.sv */
// Purpose: Input multiplexer select for the converter
// Assumes: Channel code from the control register
// Notes: Reserved codes are steered to the low reference
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module adcsq_mux (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Channel code in, source out
    input wire logic [3:0] ch,
    output logic [3:0] src_r
);
    typedef struct packed {
        logic [3:0] src;
    } adcsq_mux_s;
    adcsq_mux_s q, n;
    always_comb
    begin
        n = q;
        if (ch >= `ADCSQ_CH_RSV_LO && ch <= `ADCSQ_CH_RSV_HI)
            n.src = `ADCSQ_CH_REF_LOW; // [RULE_01] [RULE_13]
        else
            n.src = ch; // [RULE_13]
    end
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            q <= '0;
        else
            q <= n;
    end
    assign src_r = q.src;
endmodule

/* File: rtl/adcsq_sar.sv */
// Purpose: One successive-approximation conversion
// Assumes: cmp is synchronised, high when input is at or above the DAC
// Notes: 36 ticks per conversion; decision three ticks after each trial
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module adcsq_sar (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Control
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic cmp,
    // Analog side and result
    output logic sample_r,
    output logic [9:0] dac_r,
    output logic done_r
);
    typedef struct packed {
        logic active;
        logic [5:0] t;
        logic [1:0] ph;
        logic [3:0] bi;
        logic [9:0] code;
        logic sample;
        logic done;
    } adcsq_sar_s;
    adcsq_sar_s q, n;
    always_comb
    begin
        n = q;
        n.done = 1'b0;
        if (start)
        begin
            n.active = 1'b1;
            n.t = '0;
            n.ph = '0;
            n.code = '0;
            n.sample = 1'b1; // [RULE_12]
        end
        else if (abort)
        begin
            n.active = 1'b0;
            n.sample = 1'b0;
            n.code = '0;
        end
        else if (q.active && tick)
        begin
            n.t = q.t + 6'h01;
            if (q.t == `ADCSQ_SAMPLE_END)
            begin
                n.sample = 1'b0;
                n.code = `ADCSQ_DAC_MSB; // [RULE_12]
                n.bi = 4'h9;
                n.ph = '0;
            end
            else if (q.t > `ADCSQ_SAMPLE_END)
            begin
                n.ph = q.ph + 2'h1;
                if (q.ph == `ADCSQ_STEP_TICKS)
                begin
                    n.ph = '0;
                    if (!cmp)
                        n.code[q.bi] = 1'b0; // [RULE_12]
                    if (q.bi == 4'h0)
                    begin
                        n.active = 1'b0;
                        n.done = 1'b1; // [RULE_03]
                    end
                    else
                    begin
                        n.bi = q.bi - 4'h1;
                        n.code[q.bi - 4'h1] = 1'b1;
                    end
                end
            end
        end
    end
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            q <= '0;
        else
            q <= n;
    end
    assign sample_r = q.sample;
    assign dac_r = q.code;
    assign done_r = q.done;
endmodule

/* File: tb/adcsq_chk.sv */
// Purpose: Port checker for adcsq_top
// Assumes: Sample length checked at full E rate only
// Notes: Bound to the top at the foot
`timescale 1ns/1ps
module adcsq_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rd_data,
    // Analog side
    input wire logic [3:0] analog_src,
    input wire logic sample_hold,
    input wire logic [9:0] dac_code,
    input wire logic adc_enable,
    input wire logic seq_busy
);
    logic wc;
    logic wo;
    logic [3:0] src_r;
    logic [1:0] mode_r;
    assign wc = wr_stb && addr == 8'h30;
    assign wo = wr_stb && addr == 8'h39;
    // Expected source and clock mode
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            src_r <= 4'h0;
            mode_r <= 2'h0;
        end
        else
        begin
            if (wc)
                src_r <= (wr_data[3:0] > 4'h6 && wr_data[3:0] < 4'hC) ? 4'hD : wr_data[3:0];
            if (wr_stb && addr == 8'h32)
                mode_r[0] <= wr_data[0];
            if (wo)
                mode_r[1] <= wr_data[6];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_SRC: assert property (!wc && !$past(wc) |-> analog_src == src_r)
        else $error("source mismatch");
    AST_PWR: assert property (wo |=> adc_enable == $past(wr_data[7]))
        else $error("power bit mismatch");
    AST_ABORT: assert property (wo && !wr_data[7] |=> !seq_busy)
        else $error("no abort");
    AST_IDLE: assert property (!adc_enable && !(wo && wr_data[7]) |=> !seq_busy)
        else $error("busy while off");
    AST_START: assert property (wc && adc_enable |=> seq_busy)
        else $error("no start");
    AST_CLR: assert property (wc ##1 (rd_stb && addr == 8'h30) |=> !rd_data[7])
        else $error("flag not cleared");
    AST_SMP: assert property ($rose(sample_hold) && mode_r == 2'h0 && !wr_stb ##1 !wr_stb [*5]
        |-> sample_hold ##1 !sample_hold)
        else $error("sample length");
    AST_DAC: assert property ($fell(sample_hold) && adc_enable |-> dac_code == 10'h200)
        else $error("first trial");
    AST_LJ: assert property (rd_stb && addr[0] && addr[7:4] == 4'h4 |=> rd_data[5:0] == 6'h00)
        else $error("low bits set");
endmodule
bind adcsq_top adcsq_chk u_chk (.*);

/* File: tb/adcsq_ana.sv */
// Purpose: Analog inputs and comparator
// Assumes: Ideal comparator, levels as codes
// Notes: Bench loads lvl per source
`timescale 1ns/1ps
module adcsq_ana (
    // Clock
    input wire logic clock,
    // Converter side
    input wire logic [3:0] analog_src,
    input wire logic sample_hold,
    input wire logic [9:0] dac_code,
    output logic cmp_in
);
    logic [9:0] lvl [16];
    logic [9:0] held = 10'h000;
    initial
    begin
        foreach (lvl[i])
            lvl[i] = 10'h000;
        lvl[12] = 10'h3FF;
        lvl[14] = 10'h200;
    end
    always @(posedge clock)
        if (sample_hold)
            held <= lvl[analog_src];
    assign cmp_in = held >= dac_code;
endmodule

/* File: tb/tb.sv */
// Purpose: Self-checking bench for adcsq_top
// Assumes: 20 MHz E clock
// Notes: Register tasks on the strobe port
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic rc_osc = 1'b0;
    logic rc_run = 1'b0;
    logic [7:0] rd_data;
    logic [7:0] rv;
    logic cmp_in;
    logic sample_hold;
    logic adc_enable;
    logic seq_busy;
    logic [3:0] analog_src;
    logic [9:0] dac_code;
    int n_mismatch = 0;
    int n_tests = 0;
    int n;
    always #25 clock = ~clock;
    always #85 if (rc_run) rc_osc = ~rc_osc;
    adcsq_top i_adcsq_top (.*);
    adcsq_ana u_ana (.*);
    task automatic print_verdict;
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        #1;
    endtask
    task automatic rd_raw(input logic [7:0] a);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        rv = rd_data;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_raw(a);
        chk(rv, exp);
    endtask
    task automatic res(input int k, input logic [9:0] v);
        rd(8'h40 + 8'(2 * k - 2), v[9:2]);
        rd(8'h41 + 8'(2 * k - 2), {v[1:0], 6'h00});
    endtask
    task automatic run_len();
        n = 0;
        while (seq_busy !== 1'b0 && n < 2000)
        begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    task automatic wait_done();
        n = 0;
        do
            rd_raw(8'h30);
        while (rv[7] !== 1'b1 && ++n < 3000);
        chk(rv & 8'h80, 8'h80);
    endtask
    initial
    begin
        #(30000 * 50);
        n_mismatch++;
        print_verdict();
    end
    initial
    begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        #1;
        rd(8'h32, 8'h00);
        rd(8'h39, 8'h00);
        rd(8'h50, 8'h00);
        u_ana.lvl[2] = 10'h2A5;
        wr(8'h30, 8'h02);
        chk(8'(seq_busy), 8'h00);
        wr(8'h39, 8'h80);
        repeat (2000) @(posedge clock);
        #1;
        wr(8'h30, 8'h02);
        rd(8'h30, 8'h02);
        run_len();
        chk(8'(n >= 144 && n <= 170), 8'h01);
        rd(8'h30, 8'h82);
        for (int k = 5; k <= 8; k++)
            res(k, 10'h2A5);
        res(1, 10'h000);
        u_ana.lvl[13] = 10'h0C3;
        wr(8'h32, 8'h01);
        wr(8'h30, 8'h49);
        run_len();
        chk(8'(n >= 576 && n <= 640), 8'h01);
        for (int k = 1; k <= 8; k++)
            res(k, 10'h0C3);
        wr(8'h32, 8'h00);
        wr(8'h30, 8'h2C);
        wait_done();
        res(5, 10'h3FF);
        u_ana.lvl[12] = 10'h101;
        repeat (200) @(posedge clock);
        #1;
        for (int k = 5; k <= 8; k++)
            res(k, 10'h101);
        res(4, 10'h0C3);
        rd(8'h30, 8'hAC);
        wr(8'h30, 8'h61);
        wait_done();
        u_ana.lvl[1] = 10'h155;
        repeat (400) @(posedge clock);
        #1;
        for (int k = 1; k <= 8; k++)
            res(k, 10'h155);
        wr(8'h39, 8'h00);
        chk(8'({seq_busy, adc_enable}), 8'h00);
        u_ana.lvl[3] = 10'h3C7;
        rc_run = 1'b1;
        wr(8'h39, 8'hC0);
        repeat (2000) @(posedge clock);
        #1;
        wr(8'h30, 8'h03);
        wait_done();
        for (int k = 5; k <= 8; k++)
            res(k, 10'h3C7);
        print_verdict();
    end
endmodule
